// File: rtl/cfr_consts.vh
// Offsets, field layout and reset values for the filter routing block
`ifndef CFR_CONSTS_VH
`define CFR_CONSTS_VH
`define CFR_ADDR_W        4
`define CFR_OFS_CTRL_12   4'h0
`define CFR_OFS_CTRL_16   4'h4
`define CFR_OFS_CTRL_20   4'h8
`define CFR_OFS_STATUS    4'hC
`define CFR_NUM_FILT      12
`define CFR_FIRST_FILT    12
`define CFR_EN_BIT        7
`define CFR_PTR_W         5
`define CFR_BYTE_MASK     8'h9F
`define CFR_RESET_VAL     32'h00000000
`define CFR_PTR_RESERVED  5'h00
`endif

// File: rtl/cfr_ctrl_mem.v
// Filter control byte store: twelve bytes, registered read port
`timescale 1ns/1ps
`include "cfr_consts.vh"
module cfr_ctrl_mem (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire [1:0]  wr_word,
   input  wire        wr_en,
   input  wire [3:0]  wr_be,
   input  wire [31:0] wr_data,
   input  wire [1:0]  rd_word,
   output reg  [31:0] rd_data_q,
   output wire [95:0] all_bytes
);
   reg [7:0] byte_q [0:11];
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : g_byte
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               byte_q[g] <= 8'h00;
            end else if (wr_en && wr_word == (g / 4) && wr_be[g % 4]) begin
               byte_q[g] <= wr_data[(g%4)*8 +: 8] & `CFR_BYTE_MASK;
            end
         end
         assign all_bytes[g*8 +: 8] = byte_q[g];
      end
   endgenerate
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_data_q <= `CFR_RESET_VAL;
      end else begin
         rd_data_q <= {byte_q[rd_word*4+3], byte_q[rd_word*4+2],
                       byte_q[rd_word*4+1], byte_q[rd_word*4]};
      end
   end
endmodule // cfr_ctrl_mem

// File: rtl/cfr_route.v
// Receive filter routing for filters 12 to 23 with an Avalon-MM register slave
// How it works
// - Enable bit set lets filter accept messages
// - Enabled hit stores message in pointed object
// - Pointer zero is reserved; never routed there
// - Bits 6-5 ignore writes, read zero
// - Four filters per word, higher filter higher byte
// - Reset clears all fields; fields are read/write
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cfr_consts.vh"
module cfr_route (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire [11:0] filt_hit,
   output reg         route_valid_q,
   output reg  [4:0]  route_object_q,
   output reg  [3:0]  route_filter_q,
   output reg         route_reject_q
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_DONE = 3'b100;

   reg  [2:0]  state_q;
   reg         sel_status_q;
   reg         sel_bad_q;
   reg  [31:0] rej_count_q;
   wire [31:0] mem_rd;
   wire [95:0] all_bytes;
   wire        req = avs_read | avs_write;

   // Address decode: returns word index 0-2, or 3 for others
   function [1:0] word_of;
      input [3:0] a;
      begin
         if (a == `CFR_OFS_CTRL_12) word_of = 2'd0;
         else if (a == `CFR_OFS_CTRL_16) word_of = 2'd1;
         else if (a == `CFR_OFS_CTRL_20) word_of = 2'd2;
         else word_of = 2'd3;
      end
   endfunction

   wire wr_ctrl = (state_q == ST_IDLE) && avs_write && word_of(avs_address) != 2'd3;

   cfr_ctrl_mem u_mem (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .wr_word   (word_of(avs_address)),
      .wr_en     (wr_ctrl),
      .wr_be     (avs_byteenable),
      .wr_data   (avs_writedata),
      .rd_word   (word_of(avs_address)), // Address held, so read register is ready in WAIT
      .rd_data_q (mem_rd),
      .all_bytes (all_bytes)
   );

   // Slave: IDLE takes request, WAIT lets read register settle and drops waitrequest, DONE raises it again
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q         <= ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         sel_status_q    <= 1'b0;
         sel_bad_q       <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               avs_waitrequest <= 1'b1;
               if (req) begin
                  sel_status_q <= (avs_address == `CFR_OFS_STATUS);
                  sel_bad_q    <= (word_of(avs_address) == 2'd3) &&
                                  (avs_address != `CFR_OFS_STATUS);
                  state_q      <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (sel_status_q) avs_readdata <= rej_count_q;
               else if (sel_bad_q) avs_readdata <= 32'h00000000;
               else avs_readdata <= mem_rd;
               avs_waitrequest <= 1'b0;
               state_q         <= ST_DONE;
            end
            ST_DONE: begin
               avs_waitrequest <= 1'b1;
               state_q         <= ST_IDLE;
            end
            default: begin
               state_q         <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Lowest-numbered enabled hit wins when several filters hit at once
   reg        sel_found;
   reg [3:0]  sel_idx;
   reg [4:0]  sel_ptr;
   integer    i;
   always @* begin
      sel_found = 1'b0;
      sel_idx   = 4'd0;
      sel_ptr   = 5'd0;
      for (i = 11; i >= 0; i = i - 1) begin
         if (filt_hit[i] && all_bytes[i*8 + `CFR_EN_BIT]) begin
            sel_found = 1'b1;
            sel_idx   = i[3:0];
            sel_ptr   = all_bytes[i*8 +: `CFR_PTR_W];
         end
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         route_valid_q  <= 1'b0;
         route_object_q <= 5'd0;
         route_filter_q <= 4'd0;
         route_reject_q <= 1'b0;
         rej_count_q    <= 32'h00000000;
      end else begin
         // Reserved pointer never reaches object storage; flagged instead
         route_valid_q  <= sel_found && sel_ptr != `CFR_PTR_RESERVED;
         route_reject_q <= sel_found && sel_ptr == `CFR_PTR_RESERVED;
         route_object_q <= sel_found ? sel_ptr : 5'd0;
         route_filter_q <= sel_idx;
         if (sel_found && sel_ptr == `CFR_PTR_RESERVED)
            rej_count_q <= {rej_count_q[31:16] + 16'h0001, 12'h000, sel_idx};
         else if (sel_found)
            rej_count_q <= {rej_count_q[31:16], 12'h000, sel_idx};
      end
   end
endmodule // cfr_route

// File: tb/cfr_far_model.sv
// Far side: acceptance hits out, receive object store in
`timescale 1ns/1ps
module cfr_far_model (
   input  wire        sys_clk,
   input  wire [11:0] hit_req,
   input  wire        route_valid_q,
   input  wire [4:0]  route_object_q,
   input  wire [3:0]  route_filter_q,
   input  wire        route_reject_q,
   output reg  [3:0]  stored_filt = 4'h0,
   output reg  [7:0]  n_reject = 8'h00,
   output reg  [11:0] filt_hit = 12'h000,
   output reg  [4:0]  stored_obj = 5'h00,
   output reg  [7:0]  n_stored = 8'h00
);
   always @(posedge sys_clk) begin
      filt_hit <= hit_req;
      if (route_valid_q) begin
         stored_obj <= route_object_q;
         stored_filt <= route_filter_q;
         n_stored <= n_stored + 8'h01;
      end
      if (route_reject_q) n_reject <= n_reject + 8'h01;
   end
endmodule // cfr_far_model

// File: tb/cfr_route_assertions.sv
// Port checker for the filter routing block
`timescale 1ns/1ps
module cfr_route_assertions (input wire sys_clk, input wire rst_n, input wire [3:0] avs_address,
   input wire avs_read, input wire avs_write, input wire [31:0] avs_readdata,
   input wire avs_waitrequest, input wire [11:0] filt_hit, input wire route_valid_q,
   input wire [4:0] route_object_q, input wire [3:0] route_filter_q, input wire route_reject_q);
   reg [11:0] hit_q;
   wire req = avs_read | avs_write;
   always @(posedge sys_clk) hit_q <= filt_hit;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait");
   a_wait_late: assert property ($fell(avs_waitrequest) |-> $past(req, 2)) else $error("late");
   a_obj_set: assert property (route_valid_q |-> route_object_q != 5'h00) else $error("o");
   a_valid_rej: assert property (!(route_valid_q && route_reject_q)) else $error("b");
   a_hit_cause: assert property (route_valid_q |-> hit_q[route_filter_q]) else $error("c");
   a_no_hit: assert property (hit_q == 12'h000 |-> !route_valid_q && !route_reject_q)
      else $error("h");
   a_obj_idle: assert property (!route_valid_q |-> route_object_q == 5'h00) else $error("i");
   a_rsvd_zero: assert property (!avs_waitrequest && avs_read && avs_address != 4'hC |->
      (avs_readdata & 32'h60606060) == 32'h0) else $error("r");
   c_route: cover property (route_valid_q);
   c_reject: cover property (route_reject_q);
   c_write: cover property (!avs_waitrequest && avs_write);
endmodule // cfr_route_assertions
bind cfr_route cfr_route_assertions chk (.*);

// File: tb/cfr_route_test.sv
// Self-checking bench for the filter routing block
`timescale 1ns/1ps
module cfr_route_test;
   reg sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   reg [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
   reg [31:0] avs_writedata = 32'h0, rd;
   reg [11:0] hit_req = 12'h000;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, route_valid_q, route_reject_q;
   wire [4:0] route_object_q, stored_obj;
   wire [3:0] route_filter_q, stored_filt;
   wire [7:0] n_reject;
   wire [11:0] filt_hit;
   wire [7:0] n_stored;
   integer n_mismatch = 0, samples_checked = 0, i, k;
   cfr_route dut (.*);
   cfr_far_model far (.*);
   task check(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // Request held until waitrequest is seen low at an edge
   task bus(input wr, input [3:0] a, input [31:0] d, input [3:0] be);
      begin
         @(posedge sys_clk);
         avs_write <= wr;
         avs_read <= !wr;
         avs_address <= a;
         avs_writedata <= d;
         avs_byteenable <= be;
         k = 0;
         do begin
            @(posedge sys_clk);
            k = k + 1;
         end while (avs_waitrequest !== 1'b0 && k < 50);
         if (avs_waitrequest !== 1'b0) check(1, 0);
         if (avs_waitrequest !== 1'b0) give_verdict;
         rd = avs_readdata;
         avs_write <= 0;
         avs_read <= 0;
      end
   endtask
   task hit(input [11:0] h);
      begin
         @(posedge sys_clk);
         hit_req <= h;
         @(posedge sys_clk);
         hit_req <= 12'h000;
         repeat (3) @(posedge sys_clk);
      end
   endtask
   task s_regs;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            bus(0, 4'(4 * i), 0, 0);
            check(rd, 0);
         end
         bus(1, 4'h8, 32'hFFFFFFFF, 4'hF);
         bus(0, 4'h8, 0, 0);
         check(rd, 32'h9F9F9F9F);
         bus(0, 4'h1, 0, 0);
         check(rd, 0);
      end
   endtask
   task s_route;
      begin
         for (i = 0; i < 12; i = i + 1) begin
            bus(1, 4'(i / 4 * 4), {4{8'(8'h9F - i)}}, 4'(1 << i % 4));
            hit(12'(1 << i));
            check(stored_obj, 31 - i);
            check(stored_filt, i);
         end
         hit(12'hFFF);
         check(stored_obj, 31);
      end
   endtask
   task s_reject;
      begin
         bus(1, 4'h0, 32'h1F, 4'h1);
         hit(12'h001);
         check(n_stored, 13);
         bus(1, 4'h0, 32'h80, 4'h1);
         hit(12'h001);
         check(n_stored, 13);
         bus(0, 4'hC, 0, 0);
         check(rd[31:16], 1);
         check(rd[3:0], 0);
         check(n_reject, 1);
      end
   endtask
   task s_reset;
      begin
         @(posedge sys_clk);
         rst_n <= 0;
         repeat (10) @(posedge sys_clk);
         rst_n <= 1;
         bus(0, 4'h0, 0, 0);
         check(rd, 0);
         hit(12'h001);
         check(n_stored, 13);
      end
   endtask
   initial forever #25 sys_clk = ~sys_clk;
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1;
      s_regs;
      s_route;
      s_reject;
      s_reset;
      give_verdict;
   end
endmodule // cfr_route_test
